// ### verilog/tas_consts.vh
`ifndef TAS_CONSTS_VH
`define TAS_CONSTS_VH
// Command codes on the host command channel.
`define TAS_CMD_NOP        4'h0
`define TAS_CMD_ARM_ONCE   4'h1
`define TAS_CMD_REPEAT_SET 4'h2
`define TAS_CMD_REPEAT_QRY 4'h3
`define TAS_CMD_FMT_SET    4'h4
`define TAS_CMD_FMT_QRY    4'h5
`define TAS_CMD_ABORT      4'h6
`define TAS_CMD_INST_ABORT 4'h7
`define TAS_CMD_IMPL_ABORT 4'h8
`define TAS_CMD_RESET      4'h9
// Argument encodings.
`define TAS_ARG_OFF        2'h0
`define TAS_ARG_ON         2'h1
// Format values.
`define TAS_FMT_ASCII      1'b0
`define TAS_FMT_BINARY     1'b1
// Trigger source code of the software (immediate) source.
`define TAS_SRC_SOFTWARE   2'h0
// Reset values.
`define TAS_RST_FMT        1'b0
`define TAS_RST_REPEAT     1'b0
// Sequencer states.
`define TAS_ST_IDLE        2'h0
`define TAS_ST_ARMED       2'h1
`define TAS_ST_RUNNING     2'h2
// Block header and closing bytes for an indefinite-length arbitrary block.
`define TAS_BLK_HASH       8'h23
`define TAS_BLK_ZERO       8'h30
`define TAS_BLK_TERM       8'h0A
`endif

// ### verilog/tas_block_fmt.v
`timescale 1ns/1ps
`default_nettype none
`include "tas_consts.vh"
// Frames returned trace data: in binary mode a "#0" header precedes the raw
// bytes and a newline closes the block; in ASCII mode bytes pass unchanged.
module tas_block_fmt (
	// Clock and reset
	input  wire       i_clk_sys,
	input  wire       i_rst,
	// Control
	input  wire       i_fmt_binary,
	// Data in from the waveform engine
	input  wire       i_dat_valid,
	input  wire [7:0] i_dat,
	input  wire       i_dat_last,
	// Framed data to the host
	output reg        o_out_valid,
	output reg  [7:0] o_out
);
	localparam PH_HDR0 = 2'h0;
	localparam PH_HDR1 = 2'h1;
	localparam PH_BODY = 2'h2;
	localparam PH_TERM = 2'h3;
	reg [1:0] ph_ff;
	// The header takes two output slots while the source keeps streaming with
	// no back-pressure, so in binary mode every byte runs through a two-stage delay line.
	reg       s1_v_ff;
	reg [7:0] s1_d_ff;
	reg       s1_l_ff;
	reg       s2_v_ff;
	reg [7:0] s2_d_ff;
	reg       s2_l_ff;
	// The source must leave three idle cycles after the last byte of a block,
	// while the last byte and the closing newline drain out.
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			ph_ff       <= PH_HDR0;
			s1_v_ff     <= 1'b0;
			s1_d_ff     <= 8'h00;
			s1_l_ff     <= 1'b0;
			s2_v_ff     <= 1'b0;
			s2_d_ff     <= 8'h00;
			s2_l_ff     <= 1'b0;
			o_out_valid <= 1'b0;
			o_out       <= 8'h00;
		end else begin
			o_out_valid <= 1'b0;
			s1_v_ff     <= i_dat_valid;
			s1_d_ff     <= i_dat;
			s1_l_ff     <= i_dat_last;
			s2_v_ff     <= s1_v_ff;
			s2_d_ff     <= s1_d_ff;
			s2_l_ff     <= s1_l_ff;
			case (ph_ff)
			PH_HDR0: begin
				if (i_dat_valid) begin
					if (i_fmt_binary) begin
						o_out        <= `TAS_BLK_HASH;
						o_out_valid  <= 1'b1;
						ph_ff        <= PH_HDR1;
					end else begin
						o_out       <= i_dat;
						o_out_valid <= 1'b1;
					end
				end
			end
			PH_HDR1: begin
				o_out       <= `TAS_BLK_ZERO;
				o_out_valid <= 1'b1;
				ph_ff       <= PH_BODY;
			end
			PH_BODY: begin
				if (s2_v_ff) begin
					o_out       <= s2_d_ff;
					o_out_valid <= 1'b1;
					if (s2_l_ff)
						ph_ff <= PH_TERM;
				end
			end
			PH_TERM: begin
				o_out       <= `TAS_BLK_TERM;
				o_out_valid <= 1'b1;
				ph_ff       <= PH_HDR0;
			end
			default: ph_ff <= PH_HDR0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### verilog/tas_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "tas_consts.vh"
module tas_sequencer (
	// Clock and reset
	input  wire       i_clk_sys,
	input  wire       i_rst,
	// Host command channel
	input  wire       i_cmd_valid,
	input  wire [3:0] i_cmd,
	input  wire [1:0] i_cmd_arg,
	output reg        o_rsp_valid,
	output reg  [7:0] o_rsp,
	output reg        o_cmd_error,
	// Trigger engine
	input  wire [1:0] i_trig_src,
	input  wire       i_seq_done,
	output reg        o_seq_start,
	output reg        o_trig_enable,
	output reg  [1:0] o_state,
	output reg        o_fmt_binary,
	// Returned trace data
	input  wire       i_dat_valid,
	input  wire [7:0] i_dat,
	input  wire       i_dat_last,
	output wire       o_out_valid,
	output wire [7:0] o_out
);
	// The armed code is kept free so that the state port matches the engine's
	// view; the sequencer goes straight from idle to running.
	localparam ST_IDLE    = 2'h0;
	localparam ST_ARMED   = 2'h1;
	localparam ST_RUNNING = 2'h2;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg       repeat_ff;
	reg       nxt_repeat;
	reg       fmt_ff;
	reg       nxt_fmt;
	reg       start_ff;
	reg       nxt_start;
	reg       err_ff;
	reg       nxt_err;
	reg       rsp_v_ff;
	reg       nxt_rsp_v;
	reg [7:0] rsp_ff;
	reg [7:0] nxt_rsp;
	reg       trig_ff;
	reg       nxt_trig;
	wire      cmd_go;
	wire      is_abort;
	wire      arg_on;
	wire      arg_ok;

	assign cmd_go   = i_cmd_valid;
	// A reset command is grouped with the aborts: it must stop triggers and
	// clear the repeat flag as well.
	assign is_abort = cmd_go && (i_cmd == `TAS_CMD_ABORT || i_cmd == `TAS_CMD_INST_ABORT ||
	                             i_cmd == `TAS_CMD_IMPL_ABORT || i_cmd == `TAS_CMD_RESET);
	// The host parser maps ON to 1 and OFF to 0 before the channel.
	assign arg_on   = (i_cmd_arg == `TAS_ARG_ON);
	assign arg_ok   = (i_cmd_arg == `TAS_ARG_ON) || (i_cmd_arg == `TAS_ARG_OFF);

	// Converts a flag into an ASCII digit for query answers.
	function [7:0] tas_digit;
		input flag;
		begin
			tas_digit = flag ? 8'h31 : 8'h30;
		end
	endfunction

	always @* begin
		nxt_state  = state_ff;
		nxt_repeat = repeat_ff;
		nxt_fmt    = fmt_ff;
		nxt_start  = 1'b0;
		nxt_err    = 1'b0;
		nxt_rsp_v  = 1'b0;
		nxt_rsp    = rsp_ff;
		// A completed sequence is handled before the command decode, so that a
		// query in the same cycle cannot swallow the restart of a repeat.
		if (state_ff == ST_RUNNING && i_seq_done) begin
			if (repeat_ff) begin
				nxt_start = 1'b1;
				nxt_state = ST_RUNNING;
			end else begin
				nxt_state = ST_IDLE;
			end
		end
		if (is_abort) begin
			nxt_repeat = `TAS_RST_REPEAT;
			nxt_state  = ST_IDLE;
			nxt_start  = 1'b0;
			// Only a reset restores the ASCII format; aborts keep the
			// format as it stands.
			if (i_cmd == `TAS_CMD_RESET)
				nxt_fmt = `TAS_RST_FMT;
		end else if (cmd_go) begin
			case (i_cmd)
			`TAS_CMD_ARM_ONCE: begin
				// A refused arm leaves the state alone, so a running repeat
				// carries on undisturbed.
				// one-shot source check
				if (i_trig_src != `TAS_SRC_SOFTWARE) begin
					nxt_err = 1'b1;
				end else begin
					nxt_state = ST_RUNNING;
					nxt_start = 1'b1;
				end
			end
			`TAS_CMD_REPEAT_SET: begin
				if (!arg_ok) begin
					nxt_err = 1'b1;
				end else begin
					nxt_repeat = arg_on;
					if (arg_on) begin
						nxt_state = ST_RUNNING;
						nxt_start = 1'b1;
					end else begin
						nxt_state = ST_IDLE;
						nxt_start = 1'b0;
					end
				end
			end
			`TAS_CMD_REPEAT_QRY: begin
				nxt_rsp_v = 1'b1;
				nxt_rsp   = tas_digit(repeat_ff);
			end
			`TAS_CMD_FMT_SET: begin
				nxt_fmt = i_cmd_arg[0];
			end
			`TAS_CMD_FMT_QRY: begin
				nxt_rsp_v = 1'b1;
				nxt_rsp   = tas_digit(fmt_ff);
			end
			`TAS_CMD_NOP: begin
				nxt_err = 1'b0;
			end
			default: nxt_err = 1'b1;
			endcase
		end
		// Trigger enable is registered from the next state, so the port
		// comes straight from a flop and agrees with the state port.
		nxt_trig = (nxt_state == ST_RUNNING);
	end

	// Query answers stay on o_rsp until the next query, so a slow host can
	// still read them after the valid pulse has gone.
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_ff <= ST_IDLE;
			repeat_ff <= `TAS_RST_REPEAT;
			fmt_ff    <= `TAS_RST_FMT;
			start_ff  <= 1'b0;
			err_ff    <= 1'b0;
			rsp_v_ff  <= 1'b0;
			rsp_ff    <= 8'h00;
			trig_ff   <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			repeat_ff <= nxt_repeat;
			fmt_ff    <= nxt_fmt;
			start_ff  <= nxt_start;
			err_ff    <= nxt_err;
			rsp_v_ff  <= nxt_rsp_v;
			rsp_ff    <= nxt_rsp;
			trig_ff   <= nxt_trig;
		end
	end

	always @* begin
		o_state       = state_ff;
		o_seq_start   = start_ff;
		o_trig_enable = trig_ff;
		o_fmt_binary  = fmt_ff;
		o_cmd_error   = err_ff;
		o_rsp_valid   = rsp_v_ff;
		o_rsp         = rsp_ff;
	end

	// The framer samples the format at every byte in ASCII mode but only at the start of a binary
	// block, so a change in the middle of a binary block takes effect once that block has closed.
	// binary block framing
	tas_block_fmt u_fmt (
		.i_clk_sys    (i_clk_sys),
		.i_rst        (i_rst),
		.i_fmt_binary (fmt_ff),
		.i_dat_valid  (i_dat_valid),
		.i_dat        (i_dat),
		.i_dat_last   (i_dat_last),
		.o_out_valid  (o_out_valid),
		.o_out        (o_out)
	);
endmodule
`default_nettype wire

// ### verification/tas_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tas_seq_chk (
	input wire       i_clk_sys, i_rst, i_cmd_valid, i_seq_done,
	input wire       i_dat_valid, i_dat_last,
	input wire [3:0] i_cmd,
	input wire [1:0] i_cmd_arg, i_trig_src, o_state,
	input wire       o_rsp_valid, o_cmd_error, o_seq_start, o_trig_enable,
	input wire       o_fmt_binary, o_out_valid,
	input wire [7:0] o_rsp, o_out
);
	reg  rep_ff;
	wire cv   = i_cmd_valid;
	wire arg0 = i_cmd_arg[0];
	wire stop = cv && (i_cmd[3:1] == 3'h3 || i_cmd[3:1] == 3'h4 || i_cmd == 4'h2 && i_cmd_arg == 2'h0);
	wire done = i_seq_done && !cv && o_state == 2'h2;
	reg  blk_ff;
	wire blk_go = i_dat_valid && o_fmt_binary && !blk_ff;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// The repeat flag is not visible at the ports, so it is shadowed here.
	always @(posedge i_clk_sys)
		if (i_rst || stop)
			rep_ff <= 1'h0;
		else if (cv && i_cmd == 4'h2 && i_cmd_arg == 2'h1)
			rep_ff <= 1'h1;
	// A binary block is open from its first byte until its last byte.
	always @(posedge i_clk_sys)
		if (i_rst || i_dat_valid && i_dat_last)
			blk_ff <= 1'h0;
		else if (blk_go)
			blk_ff <= 1'h1;
	sequence s_hdr;
		o_out_valid && o_out == 8'h23 ##1 o_out_valid && o_out == 8'h30;
	endsequence
	sequence s_tail;
		o_out_valid && o_out == 8'h0A;
	endsequence
	a_bad_arm_err: assert property (cv && i_cmd == 4'h1 && i_trig_src != 2'h0
		|=> o_cmd_error && !o_seq_start) else $error("bad arm not flagged");
	a_arm_starts: assert property (cv && i_cmd == 4'h1 && i_trig_src == 2'h0
		|=> o_seq_start && o_state == 2'h2) else $error("arm did not start");
	a_repeat_rearm: assert property (done && rep_ff |=> o_seq_start)
		else $error("no re-arm");
	a_oneshot_idle: assert property (done && !rep_ff |=> o_state == 2'h0)
		else $error("not idle after sequence");
	a_stop_cmds: assert property (stop |=> !o_trig_enable)
		else $error("triggers not stopped");
	a_rpt_query: assert property (cv && i_cmd == 4'h3
		|=> o_rsp_valid && o_rsp == {7'h18, rep_ff}) else $error("bad repeat answer");
	a_fmt_query: assert property (cv && i_cmd == 4'h5
		|=> o_rsp_valid && o_rsp == {7'h18, o_fmt_binary} && $stable(o_fmt_binary))
		else $error("bad format answer");
	a_fmt_set: assert property (cv && i_cmd == 4'h4 |=> o_fmt_binary == $past(arg0))
		else $error("format not set");
	a_trig_running: assert property (o_trig_enable == (o_state == 2'h2))
		else $error("trigger enable off state");
	a_bin_header: assert property (blk_go |=> s_hdr)
		else $error("bad block header");
	a_bin_trailer: assert property (i_dat_valid && i_dat_last && (blk_ff || blk_go)
		|-> ##4 s_tail) else $error("bad block end");
	a_repeat_holds: assert property (o_trig_enable && rep_ff && !stop |=> o_trig_enable)
		else $error("repeat stopped early");
endmodule
bind tas_sequencer tas_seq_chk u_chk (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_seq_done(i_seq_done),
	.i_dat_valid(i_dat_valid), .i_dat_last(i_dat_last), .i_cmd(i_cmd), .i_cmd_arg(i_cmd_arg),
	.i_trig_src(i_trig_src), .o_state(o_state), .o_rsp_valid(o_rsp_valid),
	.o_cmd_error(o_cmd_error), .o_seq_start(o_seq_start), .o_trig_enable(o_trig_enable),
	.o_fmt_binary(o_fmt_binary), .o_out_valid(o_out_valid), .o_rsp(o_rsp), .o_out(o_out)
);
`default_nettype wire

// ### verification/tas_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module tas_engine_model (
	input wire       i_clk_sys,
	input wire       i_rst,
	input wire       i_seq_start,
	input wire [3:0] i_dly,
	output reg       o_seq_done
);
	reg [3:0] cnt_ff;
	reg       busy_ff;
	initial o_seq_done = 1'h0;
	// A start that lands while busy restarts the count, as a real engine would.
	always @(negedge i_clk_sys) begin
		o_seq_done <= 1'h0;
		if (i_rst) begin
			busy_ff <= 1'h0;
		end else if (i_seq_start) begin
			busy_ff <= 1'h1;
			cnt_ff <= i_dly;
		end else if (busy_ff && cnt_ff == 4'h0) begin
			o_seq_done <= 1'h1;
			busy_ff <= 1'h0;
		end else if (busy_ff) begin
			cnt_ff <= cnt_ff - 4'h1;
		end
	end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	reg       i_clk_sys = 1'h0, i_rst = 1'h1, i_cmd_valid = 1'h0;
	reg       i_dat_valid = 1'h0, i_dat_last = 1'h0;
	reg [3:0] i_cmd = 4'h0, dly = 4'h3;
	reg [1:0] i_cmd_arg = 2'h0, i_trig_src = 2'h0;
	reg [7:0] i_dat = 8'h00;
	wire      i_seq_done, o_rsp_valid, o_cmd_error, o_seq_start;
	wire      o_trig_enable, o_fmt_binary, o_out_valid;
	wire [1:0] o_state;
	wire [7:0] o_rsp, o_out;
	integer   num_errors = 0, tests_run = 0, cyc = 0, n, k;
	reg [7:0] got [$];
	always #4 i_clk_sys = ~i_clk_sys;
	tas_sequencer u_tas_sequencer (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_cmd_arg(i_cmd_arg),
		.o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_cmd_error(o_cmd_error),
		.i_trig_src(i_trig_src), .i_seq_done(i_seq_done), .o_seq_start(o_seq_start),
		.o_trig_enable(o_trig_enable), .o_state(o_state), .o_fmt_binary(o_fmt_binary),
		.i_dat_valid(i_dat_valid), .i_dat(i_dat), .i_dat_last(i_dat_last),
		.o_out_valid(o_out_valid), .o_out(o_out));
	tas_engine_model u_tas_engine_model (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_seq_start(o_seq_start), .i_dly(dly), .o_seq_done(i_seq_done));
	always @(negedge i_clk_sys) begin
		if (o_out_valid)
			got.push_back(o_out);
		cyc = cyc + 1;
		if (cyc == 3000) begin
			num_errors = num_errors + 1;
			results;
		end
	end
	task results;
		begin
			$display("checks %0d errors %0d", tests_run, num_errors);
			if (num_errors == 0 && tests_run > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task chk(input [8:0] g, input [8:0] e);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				$display("Error t=%0t got %h exp %h", $time, g, e);
				num_errors = num_errors + 1;
			end
		end
	endtask
	task cmd(input [3:0] c, input [1:0] a);
		begin
			@(negedge i_clk_sys);
			i_cmd_valid = 1'h1;
			i_cmd = c;
			i_cmd_arg = a;
			@(negedge i_clk_sys);
			i_cmd_valid = 1'h0;
		end
	endtask
	task t_fmt;
		for (k = 0; k < 2; k = k + 1) begin
			cmd(4'h4, k[1:0]);
			chk(o_fmt_binary, k);
			cmd(4'h5, 2'h0);
			chk({o_rsp_valid, o_rsp}, {1'h1, 7'h18, k[0]});
			chk(o_fmt_binary, k);
		end
		$display("format test done");
	endtask
	task t_arm;
		for (k = 0; k < 4; k = k + 1) begin
			i_trig_src = k[1:0];
			cmd(4'h1, 2'h0);
			chk({o_seq_start, o_cmd_error}, (k == 0) ? 9'h2 : 9'h1);
			repeat (8) @(negedge i_clk_sys);
			chk(o_state, 9'h0);
		end
		$display("one-shot test done");
	endtask
	task t_rep;
		for (k = 0; k < 5; k = k + 1) begin
			i_trig_src = k[1:0];
			dly = 4'h1 + k[3:0];
			cmd(4'h2, 2'h1);
			chk(o_seq_start, 9'h1);
			n = 0;
			repeat (20) @(negedge i_clk_sys) n = n + o_seq_start;
			chk(n >= 2, 9'h1);
			cmd(4'h3, 2'h0);
			chk(o_rsp, 9'h31);
			n = 0;
			repeat (20) @(negedge i_clk_sys) n = n + o_seq_start;
			chk(n >= 2, 9'h1);
			cmd((k == 0) ? 4'h2 : 4'h5 + k[3:0], 2'h0);
			chk(o_trig_enable, 9'h0);
			repeat (8) @(negedge i_clk_sys);
			chk(o_trig_enable, 9'h0);
			cmd(4'h3, 2'h0);
			chk(o_rsp, 9'h30);
			cmd(4'h2, 2'h2);
			chk(o_cmd_error, 9'h1);
		end
		$display("repeat test done");
	endtask
	task t_dat(input f, input [39:0] e, input integer len);
		begin
			cmd(4'h4, {1'h0, f});
			got.delete();
			i_dat_valid = 1'h1;
			i_dat = 8'hA5;
			@(negedge i_clk_sys);
			i_dat = 8'h5A;
			i_dat_last = 1'h1;
			@(negedge i_clk_sys);
			i_dat_valid = 1'h0;
			i_dat_last = 1'h0;
			i_dat = 8'hA5;
			repeat (6) @(negedge i_clk_sys);
			chk(got.size(), len);
			for (n = 0; n < len && n < got.size(); n = n + 1)
				chk(got[n], e[8 * (len - n) - 1 -: 8]);
			$display("data test done");
		end
	endtask
	initial begin
		repeat (6) @(negedge i_clk_sys);
		i_rst = 1'h0;
		t_fmt;
		t_arm;
		t_rep;
		t_dat(1'h1, 40'h2330A55A0A, 5);
		t_dat(1'h0, 40'h000000A55A, 2);
		results;
	end
endmodule
`default_nettype wire
